// >>> isq_stop.v
/*
 i2c master stop-condition sequencer with register port and interrupt.
 assumes a 20 MHz clk_sys, an open-drain bus outside, and that the byte
 engine raises byte_done after the falling edge of the ninth clock.
*/
`timescale 1ns/1ps
`include "isq_defines.vh"
module isq_stop #(
   parameter ADDR_W = `ISQ_ADDR_W
) (
   input wire clk_sys,
   input wire rst,
   input wire [ADDR_W-1:0] addr,
   input wire [7:0] wdata,
   input wire wr,
   input wire rd,
   output reg [7:0] rdata,
   input wire byte_done,
   input wire scl_in,
   output wire scl_out,
   output wire scl_oe,
   input wire sda_in,
   output wire sda_out,
   output wire sda_oe,
   output wire irq
);
   localparam S_IDLE = 6'b000001;
   localparam S_SDA_LOW = 6'b000010;
   localparam S_COUNT = 6'b000100;
   localparam S_SCL_HI = 6'b001000;
   localparam S_SDA_HI = 6'b010000;
   localparam S_TAIL = 6'b100000;

   reg [5:0] state;
   reg [7:0] reload;
   reg [7:0] brg;
   reg [7:0] buffer;
   reg halt_request_bit;
   reg halt_seen;
   reg write_collision_flag;
   reg serial_link_irq_flag;
   reg [1:0] irq_mask;
   reg hold_scl;
   reg drive_sda;
   reg [2:0] scl_sync;
   reg [2:0] sda_sync;
   reg scl_s;
   reg sda_s;

   wire busy = (state != S_IDLE);
   wire tick = (brg == 8'h00);
   wire wr_ctrl = wr && (addr == `ISQ_OFF_CTRL2);
   wire wr_buf = wr && (addr == `ISQ_OFF_BUF);
   wire wr_irq = wr && (addr == `ISQ_OFF_IRQ_STAT);
   wire [1:0] irq_stat = {write_collision_flag, serial_link_irq_flag};

   // open drain: only ever drive low
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe = hold_scl;
   assign sda_oe = drive_sda;
   assign irq = |(irq_stat & irq_mask);

   // three-stage sync; a change counts once stages two and three agree
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         scl_sync <= 3'b111;
         sda_sync <= 3'b111;
         scl_s <= 1'b1;
         sda_s <= 1'b1;
      end else begin
         scl_sync <= {scl_sync[1:0], scl_in};
         sda_sync <= {sda_sync[1:0], sda_in};
         if (scl_sync[1] == scl_sync[2])
            scl_s <= scl_sync[2];
         if (sda_sync[1] == sda_sync[2])
            sda_s <= sda_sync[2];
      end
   end

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state <= S_IDLE;
         brg <= 8'h00;
         hold_scl <= 1'b0;
         drive_sda <= 1'b0;
         halt_request_bit <= 1'b0;
         halt_seen <= 1'b0;
         serial_link_irq_flag <= 1'b0;
         write_collision_flag <= 1'b0;
         reload <= `ISQ_RELOAD_RESET;
         irq_mask <= 2'h0;
         buffer <= 8'h00;
      end else begin
         if (wr && addr == `ISQ_OFF_RELOAD)
            reload <= wdata;
         if (wr && addr == `ISQ_OFF_IRQ_MASK)
            irq_mask <= wdata[1:0];
         if (wr_irq && wdata[`ISQ_IRQ_LINK])
            serial_link_irq_flag <= 1'b0;
         if (wr_irq && wdata[`ISQ_IRQ_COLL])
            write_collision_flag <= 1'b0;
         // halt-seen clears when software writes zero to it
         if (wr && addr == `ISQ_OFF_STAT && !wdata[`ISQ_STAT_HALT_SEEN])
            halt_seen <= 1'b0;
         if (byte_done)
            hold_scl <= 1'b1;
         if (wr_buf) begin
            if (busy)
               write_collision_flag <= 1'b1;
            else
               buffer <= wdata;
         end
         if (wr_ctrl && !busy && wdata[`ISQ_CTRL2_HALT])
            halt_request_bit <= 1'b1;
         if (!tick)
            brg <= brg - 8'h01;
         case (state)
            S_IDLE: begin
               if (halt_request_bit) begin
                  drive_sda <= 1'b1;
                  hold_scl <= 1'b1;
                  state <= S_SDA_LOW;
               end
            end
            S_SDA_LOW: begin
               if (!sda_s) begin
                  brg <= reload;
                  state <= S_COUNT;
               end
            end
            S_COUNT: begin
               if (tick) begin
                  hold_scl <= 1'b0;
                  brg <= reload;
                  state <= S_SCL_HI;
               end
            end
            S_SCL_HI: begin
               // stretched scl reloads the count until the line is high
               if (!scl_s)
                  brg <= reload;
               else if (tick) begin
                  drive_sda <= 1'b0;
                  state <= S_SDA_HI;
               end
            end
            S_SDA_HI: begin
               if (sda_s && scl_s) begin
                  halt_seen <= 1'b1;
                  brg <= reload;
                  state <= S_TAIL;
               end
            end
            S_TAIL: begin
               if (tick) begin
                  halt_request_bit <= 1'b0;
                  serial_link_irq_flag <= 1'b1;
                  state <= S_IDLE;
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   always @(posedge clk_sys or posedge rst) begin
      if (rst)
         rdata <= 8'h00;
      else if (rd) begin
         case (addr)
            `ISQ_OFF_CTRL2:
               rdata <= {5'h00, halt_request_bit, 2'h0};
            `ISQ_OFF_STAT:
               rdata <= {3'h0, halt_seen, 4'h0};
            `ISQ_OFF_BUF: rdata <= buffer;
            `ISQ_OFF_RELOAD: rdata <= reload;
            `ISQ_OFF_IRQ_STAT: rdata <= {6'h00, irq_stat};
            `ISQ_OFF_IRQ_MASK: rdata <= {6'h00, irq_mask};
            default: rdata <= 8'h00;
         endcase
      end else
         rdata <= 8'h00;
   end
endmodule

// >>> isq_defines.vh
/*
 constants of the i2c stop sequence block: register offsets, field
 positions and reset values; assumes inclusion by bare name only
*/
`ifndef ISQ_DEFINES_VH
`define ISQ_DEFINES_VH
`define ISQ_ADDR_W 4
`define ISQ_OFF_CTRL2 4'h0
`define ISQ_OFF_STAT 4'h1
`define ISQ_OFF_BUF 4'h2
`define ISQ_OFF_RELOAD 4'h3
`define ISQ_OFF_IRQ_STAT 4'h4
`define ISQ_OFF_IRQ_MASK 4'h5
`define ISQ_CTRL2_HALT 2
`define ISQ_STAT_HALT_SEEN 4
`define ISQ_IRQ_LINK 0
`define ISQ_IRQ_COLL 1
`define ISQ_RELOAD_RESET 8'h09
`endif

// >>> isq_stop_properties.sv
/* port timing checker of the stop sequencer;
 bound to every isq_stop instance, watches its ports only */
`timescale 1ns/1ps
module isq_props (
   input wire clk_sys,
   input wire rst,
   input wire [3:0] addr,
   input wire [7:0] wdata,
   input wire wr,
   input wire rd,
   input wire [7:0] rdata,
   input wire byte_done,
   input wire scl_oe,
   input wire sda_oe,
   input wire irq
);
   reg [7:0] rl;
   reg [8:0] c;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // cycles since the pin enables last moved, saturating
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rl <= 8'h09;
         c <= 9'h000;
      end else begin
         if (wr && addr == 4'h3)
            rl <= wdata;
         c <= $changed({sda_oe, scl_oe}) ? 9'h000 : c + {8'h00, ~&c};
      end
   end
   halt_launch_a: assert property (wr && addr == 4'h0 && wdata[2]
      && !sda_oe |-> ##[1:4] sda_oe) else $error("stop not launched");
   scl_hold_a: assert property (byte_done |-> ##2 scl_oe[*6])
      else $error("scl not held low");
   sda_first_a: assert property ($rose(sda_oe) |-> scl_oe)
      else $error("sda fell with scl high");
   scl_wait_a: assert property ($fell(scl_oe) && sda_oe |-> c >= rl
      && c < {1'h0, rl} + 9'h009) else $error("scl release timing");
   sda_late_a: assert property ($fell(sda_oe) |-> !scl_oe && c >= rl)
      else $error("sda released early");
   irq_gap_a: assert property ($rose(irq) && !sda_oe && !scl_oe
      |-> c > rl) else $error("irq too early");
   irq_due_a: assert property ($fell(sda_oe) |-> ##[2:60] irq)
      else $error("irq missing");
   rd_quiet_a: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("rdata outside read");
   cover property ($fell(sda_oe));
   cover property ($rose(irq));
   cover property (byte_done ##[1:20] sda_oe);
endmodule
bind isq_stop isq_props p_u (.clk_sys(clk_sys), .rst(rst), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .byte_done(byte_done),
   .scl_oe(scl_oe), .sda_oe(sda_oe), .irq(irq));

// >>> isq_slave.sv
/* slave side of the bus: open-drain wires with pull-ups;
 assumes the bench decides when the slave stretches scl */
`timescale 1ns/1ps
module isq_slave (
   input wire scl_oe,
   input wire sda_oe,
   input wire hold,
   output wire scl,
   output wire sda
);
   assign scl = !(scl_oe || hold);
   assign sda = !sda_oe;
endmodule

// >>> isq_stop_tb.sv
/* bench of the stop sequencer: register tasks, stop runs,
 collision and masking; assumes the isq_slave bus model */
`timescale 1ns/1ps
module isq_stop_tb;
   reg clk_sys = 1'h0;
   reg rst = 1'h1;
   reg wr = 1'h0;
   reg rd = 1'h0;
   reg bd = 1'h0;
   reg hold = 1'h0;
   reg [3:0] addr = 4'h0;
   reg [7:0] wdata = 8'h00;
   wire [7:0] rdata;
   wire scl, sda, scl_oe, sda_oe, irq;
   integer n_mismatch = 0, n_tests = 0, i;
   always #25 clk_sys = !clk_sys;
   isq_stop dut_u (.clk_sys(clk_sys), .rst(rst), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .byte_done(bd),
      .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda),
      .sda_out(), .sda_oe(sda_oe), .irq(irq));
   isq_slave sl_u (.scl_oe(scl_oe), .sda_oe(sda_oe), .hold(hold),
      .scl(scl), .sda(sda));
   task chk(input [7:0] g, input [7:0] e);
      begin
         n_tests = n_tests + 1;
         if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
         end
      end
   endtask
   task wreg(input [3:0] a, input [7:0] d);
      begin
         @(posedge clk_sys);
         addr <= a;
         wdata <= d;
         wr <= 1'h1;
         @(posedge clk_sys);
         wr <= 1'h0;
      end
   endtask
   task rchk(input [3:0] a, input [7:0] e);
      begin
         @(posedge clk_sys);
         addr <= a;
         rd <= 1'h1;
         @(posedge clk_sys);
         rd <= 1'h0;
         @(negedge clk_sys);
         chk(rdata, e);
      end
   endtask
   // s: slave stretches scl and a buffer write collides
   task stop(input [7:0] r, input s);
      begin
         wreg(4'h3, r);
         // only the link flag may end the wait, not an early collision
         wreg(4'h5, 8'h01);
         @(posedge clk_sys);
         bd <= 1'h1;
         @(posedge clk_sys);
         bd <= 1'h0;
         hold <= s;
         wreg(4'h0, 8'h04);
         if (s)
            wreg(4'h2, 8'h5A);
         for (i = 0; i < 99 && scl_oe === 1'h1; i = i + 1)
            @(posedge clk_sys);
         repeat (4) @(posedge clk_sys);
         hold <= 1'h0;
         for (i = 0; i < 200 && irq !== 1'h1; i = i + 1)
            @(posedge clk_sys);
         chk({7'h00, irq}, 8'h01);
         rchk(4'h1, 8'h10);
         rchk(4'h0, 8'h00);
         rchk(4'h4, {6'h00, s, 1'h1});
         wreg(4'h5, 8'h02);
         @(negedge clk_sys);
         chk({7'h00, irq}, {7'h00, s});
         wreg(4'h5, 8'h00);
         @(negedge clk_sys);
         chk({7'h00, irq}, 8'h00);
         wreg(4'h4, 8'h03);
         wreg(4'h1, 8'h00);
         wreg(4'h5, 8'h03);
         @(negedge clk_sys);
         chk({7'h00, irq}, 8'h00);
         $display("stop run done");
      end
   endtask
   task close_out;
      begin
         $display("tests %0d mismatches %0d", n_tests, n_mismatch);
         if (n_mismatch == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   initial begin
      repeat (6) @(posedge clk_sys);
      rst <= 1'h0;
      rchk(4'h3, 8'h09);
      rchk(4'hF, 8'h00);
      stop(8'h09, 1'h0);
      wreg(4'h2, 8'hA5);
      stop(8'h02, 1'h1);
      rchk(4'h2, 8'hA5);
      close_out;
   end
   // whole run is well under 1000 cycles
   initial begin
      #200000;
      n_mismatch = n_mismatch + 1;
      close_out;
   end
endmodule
